/* gis_defs.svh */
/*
  Constants for the general interrupt status flag block: register
  offsets, field positions, reset values and masks.
  Assumes inclusion by bare name from the package and design files.
*/
`ifndef GIS_DEFS_SVH
`define GIS_DEFS_SVH

`define GIS_ADDR_W 8
`define GIS_DATA_W 24
`define GIS_RAW_W 7
`define GIS_NUM_AMPS 6

// register offsets
`define GIS_ADDR_GEN_CFG 8'h01
`define GIS_ADDR_CHAN_CTRL 8'h02
`define GIS_ADDR_STATUS 8'h07
`define GIS_ADDR_INT_EN 8'h08

// status bit positions
`define GIS_BIT_AMP_OV 8
`define GIS_BIT_MAIN_HV 7
`define GIS_BIT_OUT_HV 6
`define GIS_BIT_THERM_SHUT 5
`define GIS_BIT_THERM_WARN 4
`define GIS_BIT_OVERCUR 3
`define GIS_BIT_CFG_ERR 2
`define GIS_BIT_CRC_ERR 1
`define GIS_BIT_PIN_EDGE 0

// raw analog detector indices in the synchroniser vector
`define GIS_RAW_AMP_OV 0
`define GIS_RAW_MAIN_HV 1
`define GIS_RAW_OUT_HV 2
`define GIS_RAW_THERM_SHUT 3
`define GIS_RAW_THERM_HOT 4
`define GIS_RAW_THERM_COOL 5
`define GIS_RAW_OVERCUR 6

// general configuration and channel control field layout
`define GIS_OM_MSB 3
`define GIS_OM_LSB 0
`define GIS_FP_MSB 6
`define GIS_FP_LSB 4
`define GIS_PP_MSB 9
`define GIS_PP_LSB 7
`define GIS_AMP_MSB 15
`define GIS_AMP_LSB 10
`define GIS_OVC_MODE 16
`define GIS_CRC_EN 17
`define GIS_ADC_REF 18
`define GIS_DAC_REF 19
`define GIS_DIAG_MSB 3
`define GIS_DIAG_LSB 0

// legality limits and amplifier needs
`define GIS_OM_MAX_LEGAL 4'h8
`define GIS_PAIR_MAX_LEGAL 3'h4
`define GIS_OM_OFF 4'h0
`define GIS_DIAG_NONE 4'h0
`define GIS_AO_AMP_REQ 6'h03

// reset values and masks
`define GIS_GEN_CFG_RST 24'h000000
`define GIS_CHAN_CTRL_RST 24'h000000
`define GIS_INT_EN_RST 24'h000000
`define GIS_CFG_KEEP_MASK 24'h0e0000
`define GIS_INT_EN_MASK 24'h0001df
`define GIS_ZERO_WORD 24'h000000

`endif

/* gis_pkg.sv */
/*
  Types for the general interrupt status flag block.
  Assumes gis_defs.svh is on the include path.
*/
`default_nettype none
`include "gis_defs.svh"

package gis_pkg;

  typedef logic [`GIS_DATA_W-1:0] gis_word_t;
  typedef logic [`GIS_ADDR_W-1:0] gis_addr_t;
  typedef logic [`GIS_RAW_W-1:0] gis_raw_t;

  typedef struct packed {
    gis_raw_t s1;
    gis_raw_t s2;
    gis_raw_t s3;
    gis_raw_t level;
  } gis_sync_state_t;

  typedef struct packed {
    gis_word_t genCfg;
    gis_word_t chanCtrl;
    gis_word_t intEn;
    gis_word_t rdData;
    logic rdValid;
    logic thermShut;
    logic thermWarn;
    logic overcur;
    logic cfgErr;
    logic crcErr;
    logic pinEdge;
    logic shutPrev;
    logic irq;
  } gis_state_t;

endpackage : gis_pkg

`default_nettype wire

/* gis_status_flags.sv */
/*
  General interrupt status flags: the 24-bit status word, the enable
  word, the general configuration and channel control words whose
  writes and consistency feed the configuration error flag.
  Assumes a register port that presents one-cycle read and write
  strobes with an address, analog detectors as asynchronous levels,
  and CRC and pin-edge events as one-cycle pulses on clk.
*/
`default_nettype none
`include "gis_defs.svh"

module gis_status_flags (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // register port
  input wire logic rdStrobe,
  input wire gis_pkg::gis_addr_t rdAddr,
  output gis_pkg::gis_word_t rdData,
  output logic rdValid,
  input wire logic wrStrobe,
  input wire gis_pkg::gis_addr_t wrAddr,
  input wire gis_pkg::gis_word_t wrData,
  // analog detector levels, asynchronous
  input wire logic ampOverRange,
  input wire logic mainHvLow,
  input wire logic outHvLow,
  input wire logic thermShutTrip,
  input wire logic thermWarnHot,
  input wire logic thermWarnCool,
  input wire logic overcurDetect,
  // same-clock event pulses
  input wire logic crcFailPulse,
  input wire logic pinEdgePulse,
  // controls and interrupt out
  output logic pgaDisconnect,
  output gis_pkg::gis_word_t generalConfiguration,
  output gis_pkg::gis_word_t channelControl,
  output logic intOut
);
  import gis_pkg::*;

  // output mode codes above the legal limit are rejected
  function automatic logic modeLegal(input logic [3:0] code);
    modeLegal = (code <= `GIS_OM_MAX_LEGAL);
  endfunction : modeLegal

  // input pair codes above the legal limit are rejected
  function automatic logic pairLegal(input logic [2:0] code);
    pairLegal = (code <= `GIS_PAIR_MAX_LEGAL);
  endfunction : pairLegal

  // amplifiers needed by a diagnostic channel: channel n needs amp n-1
  function automatic logic [`GIS_NUM_AMPS-1:0] diagNeed(
      input logic [3:0] sel);
    logic [`GIS_NUM_AMPS-1:0] m;
    m = '0;
    for (int i = 0; i < `GIS_NUM_AMPS; i++) begin
      if (sel == 4'(i + 1)) begin
        m[i] = 1'b1;
      end
    end
    diagNeed = m;
  endfunction : diagNeed

  // amplifiers needed by an output mode
  function automatic logic [`GIS_NUM_AMPS-1:0] modeNeed(
      input logic [3:0] code);
    modeNeed = (code == `GIS_OM_OFF) ? '0 : `GIS_AO_AMP_REQ;
  endfunction : modeNeed

  gis_state_t st_q;
  gis_state_t st_d;
  gis_raw_t rawVec;
  gis_raw_t lvl;

  assign rawVec[`GIS_RAW_AMP_OV] = ampOverRange;
  assign rawVec[`GIS_RAW_MAIN_HV] = mainHvLow;
  assign rawVec[`GIS_RAW_OUT_HV] = outHvLow;
  assign rawVec[`GIS_RAW_THERM_SHUT] = thermShutTrip;
  assign rawVec[`GIS_RAW_THERM_HOT] = thermWarnHot;
  assign rawVec[`GIS_RAW_THERM_COOL] = thermWarnCool;
  assign rawVec[`GIS_RAW_OVERCUR] = overcurDetect;

  gis_sync u_sync (
    .clk(clk),
    .rstn(rstn),
    .rawIn(rawVec),
    .levelOut(lvl)
  );

  // live view of the status word, built from held and synced state
  gis_word_t statusWord;
  logic diagMismatch;
  logic [`GIS_NUM_AMPS-1:0] ampsNow;

  always_comb begin
    ampsNow = st_q.genCfg[`GIS_AMP_MSB:`GIS_AMP_LSB];
    diagMismatch = |(diagNeed(
        st_q.chanCtrl[`GIS_DIAG_MSB:`GIS_DIAG_LSB]) & ~ampsNow);
    statusWord = `GIS_ZERO_WORD;
    statusWord[`GIS_BIT_AMP_OV] = lvl[`GIS_RAW_AMP_OV];
    statusWord[`GIS_BIT_MAIN_HV] = lvl[`GIS_RAW_MAIN_HV];
    statusWord[`GIS_BIT_OUT_HV] = lvl[`GIS_RAW_OUT_HV];
    statusWord[`GIS_BIT_THERM_SHUT] = st_q.thermShut;
    statusWord[`GIS_BIT_THERM_WARN] = st_q.thermWarn;
    statusWord[`GIS_BIT_OVERCUR] = st_q.overcur;
    statusWord[`GIS_BIT_CFG_ERR] = st_q.cfgErr | diagMismatch;
    statusWord[`GIS_BIT_CRC_ERR] = st_q.crcErr;
    statusWord[`GIS_BIT_PIN_EDGE] = st_q.pinEdge;
  end

  logic statusRead;
  logic cfgWrite;
  logic chanWrite;
  logic shutEvent;
  logic crcEnabled;
  logic cfgErrSet;
  gis_word_t cfgNext;
  logic [`GIS_NUM_AMPS-1:0] needAmps;

  always_comb begin
    st_d = st_q;
    statusRead = rdStrobe && (rdAddr == `GIS_ADDR_STATUS);
    cfgWrite = wrStrobe && (wrAddr == `GIS_ADDR_GEN_CFG);
    chanWrite = wrStrobe && (wrAddr == `GIS_ADDR_CHAN_CTRL);
    shutEvent = lvl[`GIS_RAW_THERM_SHUT] && !st_q.shutPrev;
    crcEnabled = st_q.genCfg[`GIS_CRC_EN];
    cfgErrSet = 1'b0;
    cfgNext = st_q.genCfg;
    st_d.shutPrev = lvl[`GIS_RAW_THERM_SHUT];

    // configuration write: each code field checked on its own, an
    // illegal field keeps its old value while the rest still land
    if (cfgWrite) begin
      cfgNext = wrData;
      if (!modeLegal(wrData[`GIS_OM_MSB:`GIS_OM_LSB])) begin
        cfgNext[`GIS_OM_MSB:`GIS_OM_LSB] =
            st_q.genCfg[`GIS_OM_MSB:`GIS_OM_LSB];
        cfgErrSet = 1'b1;
      end
      if (!pairLegal(wrData[`GIS_FP_MSB:`GIS_FP_LSB])) begin
        cfgNext[`GIS_FP_MSB:`GIS_FP_LSB] =
            st_q.genCfg[`GIS_FP_MSB:`GIS_FP_LSB];
        cfgErrSet = 1'b1;
      end
      if (!pairLegal(wrData[`GIS_PP_MSB:`GIS_PP_LSB])) begin
        cfgNext[`GIS_PP_MSB:`GIS_PP_LSB] =
            st_q.genCfg[`GIS_PP_MSB:`GIS_PP_LSB];
        cfgErrSet = 1'b1;
      end
    end

    // output mode with its amplifiers off: power them and flag it;
    // checked every cycle so the register never shows the bad pair
    needAmps = modeNeed(cfgNext[`GIS_OM_MSB:`GIS_OM_LSB]);
    if ((cfgNext[`GIS_AMP_MSB:`GIS_AMP_LSB] & needAmps) != needAmps) begin
      cfgNext[`GIS_AMP_MSB:`GIS_AMP_LSB] =
          cfgNext[`GIS_AMP_MSB:`GIS_AMP_LSB] | needAmps;
      cfgErrSet = 1'b1;
    end

    // shutdown beats a same-cycle write; crc and reference selects
    // survive so the serial link keeps working after the event
    if (shutEvent) begin
      st_d.genCfg = (`GIS_GEN_CFG_RST & ~`GIS_CFG_KEEP_MASK) |
          (st_q.genCfg & `GIS_CFG_KEEP_MASK);
      st_d.chanCtrl = `GIS_CHAN_CTRL_RST;
    end else begin
      st_d.genCfg = cfgNext;
      if (chanWrite) begin
        st_d.chanCtrl = wrData;
      end
    end

    // enable word; reserved positions never store
    if (wrStrobe && (wrAddr == `GIS_ADDR_INT_EN)) begin
      st_d.intEn = wrData & `GIS_INT_EN_MASK;
    end

    // sticky flags: clear by status read, any same-cycle set wins
    st_d.thermShut = (st_q.thermShut & ~statusRead) |
        lvl[`GIS_RAW_THERM_SHUT];

    // warning holds between the hot and cool detector thresholds
    if (lvl[`GIS_RAW_THERM_HOT]) begin
      st_d.thermWarn = 1'b1;
    end else if (lvl[`GIS_RAW_THERM_COOL]) begin
      st_d.thermWarn = 1'b0;
    end

    if (st_q.genCfg[`GIS_OVC_MODE]) begin
      st_d.overcur = (st_q.overcur & ~statusRead) |
          lvl[`GIS_RAW_OVERCUR];
    end else begin
      st_d.overcur = lvl[`GIS_RAW_OVERCUR];
    end

    st_d.cfgErr = (st_q.cfgErr & ~statusRead) |
        cfgErrSet;

    st_d.crcErr = (st_q.crcErr & ~statusRead) |
        (crcFailPulse & crcEnabled);

    // status read clears only the summary; pin data lives elsewhere
    // and this block drives nothing toward it
    st_d.pinEdge = (st_q.pinEdge & ~statusRead) |
        pinEdgePulse;

    // read data shows the word as it stood before the clearing read
    st_d.rdValid = rdStrobe;
    if (rdStrobe) begin
      unique case (rdAddr)
        `GIS_ADDR_STATUS: st_d.rdData = statusWord;
        `GIS_ADDR_INT_EN: st_d.rdData = st_q.intEn;
        `GIS_ADDR_GEN_CFG: st_d.rdData = st_q.genCfg;
        `GIS_ADDR_CHAN_CTRL: st_d.rdData = st_q.chanCtrl;
        default: st_d.rdData = `GIS_ZERO_WORD;
      endcase
    end

    // one cycle of lag on the pin keeps it glitch free
    st_d.irq = |(statusWord & st_q.intEn);
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_q.genCfg <= `GIS_GEN_CFG_RST;
      st_q.chanCtrl <= `GIS_CHAN_CTRL_RST;
      st_q.intEn <= `GIS_INT_EN_RST;
      st_q.rdData <= `GIS_ZERO_WORD;
      st_q.rdValid <= 1'b0;
      st_q.thermShut <= 1'b0;
      st_q.thermWarn <= 1'b0;
      st_q.overcur <= 1'b0;
      st_q.cfgErr <= 1'b0;
      st_q.crcErr <= 1'b0;
      st_q.pinEdge <= 1'b0;
      st_q.shutPrev <= 1'b0;
      st_q.irq <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  assign rdData = st_q.rdData;
  assign rdValid = st_q.rdValid;
  assign pgaDisconnect = lvl[`GIS_RAW_AMP_OV];
  assign generalConfiguration = st_q.genCfg;
  assign channelControl = st_q.chanCtrl;
  assign intOut = st_q.irq;

endmodule : gis_status_flags

`default_nettype wire

/* gis_status_flags_bench.sv */
/*
  Self-checking bench for gis_status_flags against a flag model.
  Assumes gis_pkg and gis_defs.svh; inputs change at falling edges.
*/
`default_nettype none
`include "gis_defs.svh"

module gis_status_flags_bench import gis_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rstn = 0, rdStrobe = 0, wrStrobe = 0, rdValid, intOut;
  logic ampOverRange = 0, mainHvLow = 0, outHvLow = 0, thermShutTrip = 0;
  logic thermWarnHot = 0, thermWarnCool = 0, overcurDetect = 0;
  logic crcFailPulse = 0, pinEdgePulse = 0, pgaDisconnect;
  gis_addr_t rdAddr = 8'h00, wrAddr = 8'h00;
  gis_word_t wrData = 24'h000000, rdData, d;
  gis_word_t generalConfiguration, channelControl;
  gis_word_t mCfg = 24'h000000, mChan = 24'h000000;
  logic stShut = 0, mWarn = 0, stOvc = 0, stCfg = 0, stCrc = 0, stEdge = 0;
  logic [31:0] seed = 32'hcc83, r;
  logic [9:0] warnSeq = 10'b10_00_01_11_01;
  int errCount = 0, nChecks = 0, cycles = 0;

  gis_status_flags dut (.clk(clk), .rstn(rstn), .rdStrobe(rdStrobe),
    .rdAddr(rdAddr), .rdData(rdData), .rdValid(rdValid),
    .wrStrobe(wrStrobe), .wrAddr(wrAddr), .wrData(wrData),
    .ampOverRange(ampOverRange), .mainHvLow(mainHvLow),
    .outHvLow(outHvLow), .thermShutTrip(thermShutTrip),
    .thermWarnHot(thermWarnHot), .thermWarnCool(thermWarnCool),
    .overcurDetect(overcurDetect), .crcFailPulse(crcFailPulse),
    .pinEdgePulse(pinEdgePulse), .pgaDisconnect(pgaDisconnect),
    .generalConfiguration(generalConfiguration),
    .channelControl(channelControl), .intOut(intOut));

  always #50 clk = ~clk;

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  function automatic gis_word_t expSts();
    logic mis;
    mis = mChan[3:0] inside {[4'h1:4'h6]} && !mCfg[9 + mChan[3:0]];
    return {15'h0000, ampOverRange, mainHvLow, outHvLow, stShut, mWarn,
      mCfg[16] ? stOvc : overcurDetect, stCfg | mis, stCrc, stEdge};
  endfunction : expSts

  task automatic finishTest();
    $display("checks %0d mismatches %0d", nChecks, errCount);
    if (errCount == 0 && nChecks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finishTest

  task automatic chk(input string nm, input gis_word_t got, exp);
    nChecks++;
    if (got !== exp) begin
      errCount++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  task automatic rd(input gis_addr_t a, input logic e, output gis_word_t v);
    int i;
    rdStrobe = 1;
    rdAddr = a;
    pinEdgePulse = e;
    cyc(1);
    rdStrobe = 0;
    pinEdgePulse = 0;
    i = 0;
    while (rdValid !== 1'b1 && i < 4) begin
      cyc(1);
      i++;
    end
    v = rdData;
    cyc(1);
  endtask : rd

  task automatic wr(input gis_addr_t a, input gis_word_t v);
    wrStrobe = 1;
    wrAddr = a;
    wrData = v;
    cyc(1);
    wrStrobe = 0;
  endtask : wr

  // model of code legality and forced amplifiers
  task automatic wrCfg(input gis_word_t v);
    gis_word_t n;
    n = v;
    if (v[3:0] > 4'h8) begin n[3:0] = mCfg[3:0]; stCfg = 1; end
    if (v[6:4] > 3'h4) begin n[6:4] = mCfg[6:4]; stCfg = 1; end
    if (v[9:7] > 3'h4) begin n[9:7] = mCfg[9:7]; stCfg = 1; end
    if (n[3:0] != 4'h0 && n[11:10] != 2'h3) begin
      n[11:10] = 2'h3;
      stCfg = 1;
    end
    mCfg = n;
    wr(`GIS_ADDR_GEN_CFG, v);
    cyc(2);
  endtask : wrCfg

  // status read, then clear-on-read in the model
  task automatic chkSts(input logic e);
    gis_word_t v, x;
    x = expSts();
    rd(`GIS_ADDR_STATUS, e, v);
    chk("status", v, x);
    stShut = thermShutTrip;
    stCrc = 0;
    stEdge = e;
    stCfg = 0;
    if (mCfg[16]) stOvc = overcurDetect;
  endtask : chkSts

  task automatic pulseCrc();
    crcFailPulse = 1;
    cyc(1);
    crcFailPulse = 0;
    stCrc = mCfg[17];
    cyc(2);
  endtask : pulseCrc

  task automatic pulseEdge();
    pinEdgePulse = 1;
    cyc(1);
    pinEdgePulse = 0;
    stEdge = 1;
    cyc(3);
  endtask : pulseEdge

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      errCount++;
      finishTest();
    end
  end

  initial begin
    cyc(3);
    rstn = 1;
    rd(`GIS_ADDR_INT_EN, 0, d);
    chk("enable", d, 24'h000000);
    rd(8'h33, 0, d);
    chk("unmapped", d, 24'h000000);
    wr(`GIS_ADDR_STATUS, 24'hffffff);
    chkSts(0);
    repeat (8) begin
      r = rnd();
      wrCfg({8'h00, r[15:0]});
      chk("config", generalConfiguration, mCfg);
      chkSts(0);
    end
    r = rnd();
    for (int i = 0; i < 8; i++) begin
      {ampOverRange, mainHvLow, outHvLow} = 3'(i) ^ r[2:0];
      cyc(8);
      chk("disc", {23'h0, pgaDisconnect}, {23'h0, ampOverRange});
      chkSts(0);
    end
    {ampOverRange, mainHvLow, outHvLow} = 3'h0;
    for (int i = 0; i < 5; i++) begin
      {thermWarnHot, thermWarnCool} = warnSeq[9 - 2 * i -: 2];
      if (thermWarnHot) mWarn = 1;
      else if (thermWarnCool) mWarn = 0;
      cyc(8);
      chkSts(0);
    end
    thermWarnCool = 0;
    wrCfg(24'h0ffc08);
    wr(`GIS_ADDR_CHAN_CTRL, 24'h000a50);
    mChan = 24'h000a50;
    cyc(8);
    thermShutTrip = 1;
    mCfg = mCfg & `GIS_CFG_KEEP_MASK;
    mChan = 24'h000000;
    stShut = 1;
    cyc(10);
    chk("config", generalConfiguration, mCfg);
    chk("channel", channelControl, mChan);
    chkSts(0);
    thermShutTrip = 0;
    cyc(8);
    chkSts(0);
    chkSts(0);
    overcurDetect = 1;
    cyc(8);
    chkSts(0);
    overcurDetect = 0;
    cyc(8);
    chkSts(0);
    wrCfg(mCfg | 24'h010000);
    overcurDetect = 1;
    stOvc = 1;
    cyc(8);
    overcurDetect = 0;
    cyc(8);
    chkSts(0);
    chkSts(0);
    for (int i = 0; i < 2; i++) begin
      wrCfg(mCfg ^ 24'h020000);
      pulseCrc();
      chkSts(0);
    end
    chkSts(0);
    wr(`GIS_ADDR_INT_EN, 24'hffffff);
    rd(`GIS_ADDR_INT_EN, 0, d);
    chk("enable", d, 24'h0001df);
    pulseEdge();
    chk("interrupt", {23'h0, intOut}, 24'h000001);
    chkSts(0);
    chkSts(1);
    chkSts(0);
    cyc(3);
    chk("interrupt", {23'h0, intOut}, 24'h000000);
    wr(`GIS_ADDR_INT_EN, 24'h000000);
    pulseEdge();
    chk("interrupt", {23'h0, intOut}, 24'h000000);
    chkSts(0);
    wr(`GIS_ADDR_CHAN_CTRL, 24'h000003);
    mChan = 24'h000003;
    cyc(2);
    chkSts(0);
    chkSts(0);
    wrCfg(mCfg | 24'h001000);
    chkSts(0);
    finishTest();
  end
endmodule : gis_status_flags_bench

`default_nettype wire

/* gis_status_flags_checker.sv */
/*
  Port-level properties of gis_status_flags, bound to it below.
  Assumes the offsets and bit positions of gis_defs.svh.
*/
`default_nettype none
`include "gis_defs.svh"

module gis_status_flags_checker (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // register port
  input wire logic rdStrobe,
  input wire gis_pkg::gis_addr_t rdAddr,
  input wire gis_pkg::gis_word_t rdData,
  input wire logic rdValid,
  input wire logic wrStrobe,
  input wire gis_pkg::gis_addr_t wrAddr,
  input wire gis_pkg::gis_word_t wrData,
  // detectors
  input wire logic ampOverRange,
  input wire logic mainHvLow,
  input wire logic outHvLow,
  input wire logic thermShutTrip,
  input wire logic thermWarnCool,
  input wire logic thermWarnHot,
  input wire logic overcurDetect,
  // outputs
  input wire logic pgaDisconnect,
  input wire gis_pkg::gis_word_t generalConfiguration,
  input wire gis_pkg::gis_word_t channelControl,
  input wire logic intOut
);
  import gis_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  gis_addr_t rdAddr_q;
  gis_word_t en_q;
  logic stsRd;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rdAddr_q <= 8'h00;
      en_q <= 24'h000000;
    end else begin
      if (rdStrobe) rdAddr_q <= rdAddr;
      if (wrStrobe && wrAddr == `GIS_ADDR_INT_EN)
        en_q <= wrData & `GIS_INT_EN_MASK;
    end
  end
  // answer belongs to the last taken read address
  assign stsRd = rdValid && rdAddr_q == `GIS_ADDR_STATUS;
  property p_disc;
    ampOverRange [*6] |=> pgaDisconnect;
  endproperty
  a_disc: assert property (p_disc)
    else $error("amp inputs not disconnected");
  property p_resv;
    stsRd |-> rdData[23:9] == 15'h0000;
  endproperty
  a_resv: assert property (p_resv)
    else $error("reserved status bits not zero");
  property p_amp;
    ampOverRange [*7] ##1 stsRd |-> rdData[`GIS_BIT_AMP_OV];
  endproperty
  a_amp: assert property (p_amp)
    else $error("overvoltage bit missing");
  property p_mhv;
    mainHvLow [*7] ##1 stsRd |-> rdData[`GIS_BIT_MAIN_HV];
  endproperty
  a_mhv: assert property (p_mhv)
    else $error("main supply bit missing");
  property p_ohv;
    !outHvLow [*7] ##1 stsRd |-> !rdData[`GIS_BIT_OUT_HV];
  endproperty
  a_ohv: assert property (p_ohv)
    else $error("output supply bit stuck");
  property p_warn;
    (thermWarnCool && !thermWarnHot) [*7] ##1 stsRd
      |-> !rdData[`GIS_BIT_THERM_WARN];
  endproperty
  a_warn: assert property (p_warn)
    else $error("warning bit not cleared");
  property p_ovc;
    (!overcurDetect && !generalConfiguration[`GIS_OVC_MODE]) [*8]
      ##1 stsRd |-> !rdData[`GIS_BIT_OVERCUR];
  endproperty
  a_ovc: assert property (p_ovc)
    else $error("auto overcurrent bit stuck");
  property p_shut;
    (!thermShutTrip && !wrStrobe) [*6] ##1 (thermShutTrip && !wrStrobe) [*8]
      |-> channelControl == 24'h000000 &&
      (generalConfiguration & ~`GIS_CFG_KEEP_MASK) == 24'h000000;
  endproperty
  a_shut: assert property (p_shut)
    else $error("shutdown did not restore config");
  property p_int;
    (en_q == 24'h000000) [*3] |-> !intOut;
  endproperty
  a_int: assert property (p_int)
    else $error("interrupt with all enables off");
endmodule : gis_status_flags_checker

bind gis_status_flags gis_status_flags_checker chk (.clk, .rstn,
  .rdStrobe, .rdAddr, .rdData, .rdValid, .wrStrobe, .wrAddr, .wrData,
  .ampOverRange, .mainHvLow, .outHvLow, .thermShutTrip, .thermWarnCool,
  .thermWarnHot, .overcurDetect, .pgaDisconnect, .generalConfiguration,
  .channelControl, .intOut);

`default_nettype wire

/* gis_sync.sv */
/*
  Three-stage synchroniser for the raw analog detector levels.
  Assumes detector outputs are asynchronous levels; a change is taken
  only once the second and third stages agree.
*/
`default_nettype none
`include "gis_defs.svh"

module gis_sync (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // raw and filtered levels
  input wire gis_pkg::gis_raw_t rawIn,
  output gis_pkg::gis_raw_t levelOut
);
  import gis_pkg::*;

  gis_sync_state_t st_q;
  gis_sync_state_t st_d;

  always_comb begin
    st_d = st_q;
    st_d.s1 = rawIn;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    // per-bit update only where the two later stages agree
    for (int i = 0; i < `GIS_RAW_W; i++) begin
      if (st_q.s2[i] == st_q.s3[i]) begin
        st_d.level[i] = st_q.s3[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign levelOut = st_q.level;

endmodule : gis_sync

`default_nettype wire
